//--- design/hcfd_pkg.sv
// hcfd_pkg: constants, encodings and state types of the host command frame decoder.
// assumes byte-wide serial streams on the module clock.
package hcfd_pkg;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam logic [7:0]  HCFD_START       = 8'h02;
  localparam logic [7:0]  HCFD_CNF_OFFSET  = 8'h40;
  localparam logic [7:0]  HCFD_LEN_HI_ZERO = 8'h00;
  localparam logic [7:0]  HCFD_FILL        = 8'h00;
  localparam logic [2:0]  HCFD_HDR_BYTES   = 3'h5;
  localparam logic [15:0] HCFD_LEN_NONE    = 16'h0000;
  localparam logic [15:0] HCFD_LEN_LAST    = 16'h0001;

  // ****************************************************************
  // request opcodes
  // ****************************************************************
  localparam logic [7:0] HCFD_OP_RESET       = 8'h00;
  localparam logic [7:0] HCFD_OP_STATE_QUERY = 8'h01;
  localparam logic [7:0] HCFD_OP_SLEEP       = 8'h02;
  localparam logic [7:0] HCFD_OP_DATA        = 8'h04;
  localparam logic [7:0] HCFD_OP_CONNECT     = 8'h06;
  localparam logic [7:0] HCFD_OP_LINK_CLOSE  = 8'h07;
  localparam logic [7:0] HCFD_OP_SEARCH_BEG  = 8'h09;
  localparam logic [7:0] HCFD_OP_SEARCH_END  = 8'h0a;
  localparam logic [7:0] HCFD_OP_FOUND_PEERS = 8'h0b;
  localparam logic [7:0] HCFD_OP_ADV_PAYLOAD = 8'h0c;
  localparam logic [7:0] HCFD_OP_PIN_ANSWER  = 8'h0d;
  localparam logic [7:0] HCFD_OP_PAIR_ERASE  = 8'h0e;
  localparam logic [7:0] HCFD_OP_PAIR_LIST   = 8'h0f;
  localparam logic [7:0] HCFD_OP_SET_READ    = 8'h10;
  localparam logic [7:0] HCFD_OP_SET_WRITE   = 8'h11;
  localparam logic [7:0] HCFD_OP_RADIO_LAYER = 8'h1a;
  localparam logic [7:0] HCFD_OP_SERIAL_OFF  = 8'h1b;
  localparam logic [7:0] HCFD_OP_DEFAULTS    = 8'h1c;
  localparam logic [7:0] HCFD_OP_TEST_ENABLE = 8'h1d;
  localparam logic [7:0] HCFD_OP_TEST_CTRL   = 8'h1e;
  localparam logic [7:0] HCFD_OP_BOOTLOADER  = 8'h1f;

  // ****************************************************************
  // notice and response opcodes
  // ****************************************************************
  localparam logic [7:0] HCFD_OP_DOZE_NOTICE   = 8'h82;
  localparam logic [7:0] HCFD_OP_ARRIVAL       = 8'h84;
  localparam logic [7:0] HCFD_OP_LINK_UP       = 8'h86;
  localparam logic [7:0] HCFD_OP_LINK_DOWN     = 8'h87;
  localparam logic [7:0] HCFD_OP_LINK_SECURED  = 8'h88;
  localparam logic [7:0] HCFD_OP_ADVERT_SEEN   = 8'h8b;
  localparam logic [7:0] HCFD_OP_ADVERT_DATA   = 8'h8c;
  localparam logic [7:0] HCFD_OP_PIN_WANTED    = 8'h8d;
  localparam logic [7:0] HCFD_OP_LAYER_CHANGED = 8'h9a;
  localparam logic [7:0] HCFD_OP_SERIAL_BACK   = 8'h9b;
  localparam logic [7:0] HCFD_OP_FAULT_NOTICE  = 8'ha2;
  localparam logic [7:0] HCFD_OP_SEND_DONE     = 8'hc4;
  localparam logic [7:0] HCFD_OP_CHANNEL_READY = 8'hc6;

  // ****************************************************************
  // status codes and settings store
  // ****************************************************************
  localparam logic [7:0]  HCFD_ST_OK             = 8'h00;
  localparam logic [7:0]  HCFD_ST_SERIAL_OVERFLOW = 8'h01;
  localparam logic [7:0]  HCFD_ST_REFUSED        = 8'hff;
  localparam int          HCFD_NSET              = 16;
  localparam logic [7:0]  HCFD_NSET_B            = 8'h10;
  localparam logic [15:0] HCFD_READ_PERM         = 16'hffff;
  localparam logic [15:0] HCFD_WRITE_PERM        = 16'h0004;
  localparam logic [7:0]  HCFD_SET_RESET         = 8'h00;

  typedef logic [HCFD_NSET-1:0][7:0] hcfd_bank_t;

  typedef enum logic [5:0] {
    HCFD_RX_IDLE = 6'b000001,
    HCFD_RX_OP   = 6'b000010,
    HCFD_RX_LLO  = 6'b000100,
    HCFD_RX_LHI  = 6'b001000,
    HCFD_RX_PAY  = 6'b010000,
    HCFD_RX_CS   = 6'b100000
  } hcfd_rx_e;

  typedef struct packed {
    logic [6:0][7:0] bytes;
    logic [2:0]      cnt;
  } hcfd_frame_s;

  typedef struct packed {
    hcfd_rx_e    rx;
    logic [7:0]  sum;
    logic [7:0]  op;
    logic [15:0] rem;
    logic [1:0]  pay_idx;
    logic [7:0]  arg0;
    logic [7:0]  arg1;
    logic        cnf_pend;
    hcfd_frame_s tx;
    hcfd_bank_t  stored;
    hcfd_bank_t  active;
    logic        req_valid;
    logic [7:0]  req_op;
    logic        restart;
  } hcfd_state_s;

endpackage : hcfd_pkg

//--- design/hcfd_top.sv
// hcfd_top: framed command interpreter on the host serial port.
// assumes byte streams synchronous to clock, overflow flag from the serial core.
// Summary of operation
// - fault notice frame, opcode a2, one status
// - overflow aborts both directions, restarts, status 01
// - start byte 02; reset, query, sleep opcodes
// - user data request opcode 04
// - connect 06, close connection 07
// - search 09/0a, peers 0b, advert 0c
// - pin 0d, erase pairings 0e, list 0f
// - radio layer 1a, serial off 1b, defaults 1c
// - test enable 1d, test control 1e, bootloader 1f
// - confirmation opcode is request plus 40
// - notices 84, 8b, 8c for arrivals
// - notices 82, 9a, 9b for state changes
// - notices 86, 87, 88, 8d for links
// - responses c4 send done, c6 channel ready
// - settings read 10, written 11, permission checked
// - peripheral-only mode refuses settings access
// - written setting values stored unchecked
// - written settings apply after reset only
// - multi-byte fields least significant byte first
`timescale 1ns/1ps
module hcfd_top
  import hcfd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  input  wire logic [7:0] rx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic [7:0]      tx_data,
  input  wire logic       evt_valid,
  output logic            evt_ready,
  input  wire logic [7:0] evt_code,
  input  wire logic       serial_overflow,
  input  wire logic       peripheral_only,
  output logic            serial_restart,
  output logic            req_valid,
  output logic [7:0]      req_op,
  output logic [7:0]      req_arg,
  output hcfd_bank_t      active_settings
);

  hcfd_state_s s_q;
  hcfd_state_s s_d;
  logic        rx_take;
  logic        tx_idle;

  // ****************************************************************
  // frame helpers
  // ****************************************************************
  function automatic hcfd_frame_s build(input logic [7:0] op, input logic [1:0] plen,
                                        input logic [7:0] b0, input logic [7:0] b1);
    hcfd_frame_s f;
    logic [7:0]  cs;
    cs = HCFD_START ^ op ^ {6'h00, plen};
    if (plen != 2'h0)
      cs = cs ^ b0;
    if (plen == 2'h2)
      cs = cs ^ b1;
    f.bytes    = '0;
    f.bytes[0] = HCFD_START;
    f.bytes[1] = op;
    f.bytes[2] = {6'h00, plen};
    f.bytes[3] = HCFD_LEN_HI_ZERO;
    case (plen)
      2'h0: f.bytes[4] = cs;
      2'h1:
      begin
        f.bytes[4] = b0;
        f.bytes[5] = cs;
      end
      default:
      begin
        f.bytes[4] = b0;
        f.bytes[5] = b1;
        f.bytes[6] = cs;
      end
    endcase
    f.cnt = HCFD_HDR_BYTES + {1'b0, plen};
    return f;
  endfunction : build

  function automatic logic is_request(input logic [7:0] op);
    case (op)
      HCFD_OP_RESET, HCFD_OP_STATE_QUERY, HCFD_OP_SLEEP,
      HCFD_OP_DATA,
      HCFD_OP_CONNECT, HCFD_OP_LINK_CLOSE,
      HCFD_OP_SEARCH_BEG, HCFD_OP_SEARCH_END, HCFD_OP_FOUND_PEERS, HCFD_OP_ADV_PAYLOAD,
      HCFD_OP_PIN_ANSWER, HCFD_OP_PAIR_ERASE, HCFD_OP_PAIR_LIST,
      HCFD_OP_SET_READ, HCFD_OP_SET_WRITE,
      HCFD_OP_RADIO_LAYER, HCFD_OP_SERIAL_OFF, HCFD_OP_DEFAULTS,
      HCFD_OP_TEST_ENABLE, HCFD_OP_TEST_CTRL, HCFD_OP_BOOTLOADER: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_request

  function automatic logic is_notice(input logic [7:0] op);
    case (op)
      HCFD_OP_ARRIVAL, HCFD_OP_ADVERT_SEEN, HCFD_OP_ADVERT_DATA,
      HCFD_OP_DOZE_NOTICE, HCFD_OP_LAYER_CHANGED, HCFD_OP_SERIAL_BACK,
      HCFD_OP_LINK_UP, HCFD_OP_LINK_DOWN, HCFD_OP_LINK_SECURED, HCFD_OP_PIN_WANTED,
      HCFD_OP_SEND_DONE, HCFD_OP_CHANNEL_READY: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_notice

  assign tx_idle   = (s_q.tx.cnt == 3'h0);
  // stall the host while a confirmation waits for the transmitter
  assign rx_ready  = !s_q.cnf_pend && !serial_overflow;
  assign rx_take   = rx_valid && rx_ready;
  assign evt_ready = tx_idle && !s_q.cnf_pend && !serial_overflow;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [3:0] idx;
    logic       idx_ok;
    s_d           = s_q;
    idx           = s_q.arg0[3:0];
    idx_ok        = (s_q.arg0 < HCFD_NSET_B);
    s_d.req_valid = 1'b0;
    s_d.restart   = 1'b0;

    if (!tx_idle && tx_ready)
    begin
      s_d.tx.bytes = {HCFD_FILL, s_q.tx.bytes[6:1]};
      s_d.tx.cnt   = s_q.tx.cnt - 3'h1;
    end

    if (rx_take)
    begin
      s_d.sum = s_q.sum ^ rx_data;
      case (s_q.rx)
        HCFD_RX_IDLE:
        begin
          s_d.sum = rx_data;
          if (rx_data == HCFD_START)
            s_d.rx = HCFD_RX_OP;
        end
        HCFD_RX_OP:
        begin
          s_d.op = rx_data;
          s_d.rx = HCFD_RX_LLO;
        end
        HCFD_RX_LLO:
        begin
          s_d.rem[7:0] = rx_data;
          s_d.rx       = HCFD_RX_LHI;
        end
        HCFD_RX_LHI:
        begin
          s_d.rem[15:8] = rx_data;
          s_d.pay_idx   = 2'h0;
          s_d.arg0      = HCFD_FILL;
          s_d.arg1      = HCFD_FILL;
          s_d.rx = ({rx_data, s_q.rem[7:0]} == HCFD_LEN_NONE) ? HCFD_RX_CS : HCFD_RX_PAY;
        end
        HCFD_RX_PAY:
        begin
          if (s_q.pay_idx == 2'h0)
            s_d.arg0 = rx_data;
          if (s_q.pay_idx == 2'h1)
            s_d.arg1 = rx_data;
          if (s_q.pay_idx != 2'h3)
            s_d.pay_idx = s_q.pay_idx + 2'h1;
          s_d.rem = s_q.rem - HCFD_LEN_LAST;
          if (s_q.rem == HCFD_LEN_LAST)
            s_d.rx = HCFD_RX_CS;
        end
        HCFD_RX_CS:
        begin
          // bad checksum drops the frame silently
          if (rx_data == s_q.sum)
            s_d.cnf_pend = 1'b1;
          s_d.rx = HCFD_RX_IDLE;
        end
        default: s_d.rx = HCFD_RX_IDLE;
      endcase
    end

    if (s_q.cnf_pend && tx_idle)
    begin
      s_d.cnf_pend = 1'b0;
      if (is_request(s_q.op))
      begin
        s_d.req_valid = 1'b1;
        s_d.req_op    = s_q.op;
        s_d.tx = build(s_q.op + HCFD_CNF_OFFSET, 2'h1, HCFD_ST_OK, HCFD_FILL);
        case (s_q.op)
          HCFD_OP_SET_READ:
          begin
            if (!peripheral_only && idx_ok && HCFD_READ_PERM[idx])
              s_d.tx = build(s_q.op + HCFD_CNF_OFFSET, 2'h2, HCFD_ST_OK, s_q.stored[idx]);
            else
              s_d.tx = build(s_q.op + HCFD_CNF_OFFSET, 2'h1, HCFD_ST_REFUSED, HCFD_FILL);
          end
          HCFD_OP_SET_WRITE:
          begin
            if (!peripheral_only && idx_ok && HCFD_WRITE_PERM[idx])
              s_d.stored[idx] = s_q.arg1;
            else
              s_d.tx = build(s_q.op + HCFD_CNF_OFFSET, 2'h1, HCFD_ST_REFUSED, HCFD_FILL);
          end
          HCFD_OP_RESET: s_d.active = s_q.stored;
          default: s_d.active = s_q.active;
        endcase
      end
    end
    else if (evt_valid && evt_ready && is_notice(evt_code))
    begin
      s_d.tx = build(evt_code, 2'h0, HCFD_FILL, HCFD_FILL);
    end

    // overflow aborts both directions and restarts
    if (serial_overflow)
    begin
      s_d.rx        = HCFD_RX_IDLE;
      s_d.cnf_pend  = 1'b0;
      s_d.req_valid = 1'b0;
      s_d.restart   = 1'b1;
      // fault notice with one status byte
      s_d.tx = build(HCFD_OP_FAULT_NOTICE, 2'h1, HCFD_ST_SERIAL_OVERFLOW, HCFD_FILL);
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q        <= '0;
      s_q.rx     <= HCFD_RX_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign tx_valid        = !tx_idle;
  assign tx_data         = s_q.tx.bytes[0];
  assign serial_restart  = s_q.restart;
  assign req_valid       = s_q.req_valid;
  assign req_op          = s_q.req_op;
  assign req_arg         = s_q.arg0;
  assign active_settings = s_q.active;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_fault_frame: assert property (serial_overflow |=> tx_valid && tx_data == HCFD_START
    && s_q.tx.bytes[1] == HCFD_OP_FAULT_NOTICE && s_q.tx.bytes[4] == HCFD_ST_SERIAL_OVERFLOW)
    else $error("fault notice frame wrong");
  a_fault_restart: assert property (serial_overflow |=> serial_restart && !req_valid)
    else $error("overflow did not restart serial port");
  a_cnf_opcode: assert property (req_valid |-> s_q.tx.bytes[1] == req_op + HCFD_CNF_OFFSET
    && s_q.tx.cnt != 3'h0)
    else $error("confirmation opcode wrong");
  a_periph_refuse: assert property ((req_valid && $past(peripheral_only)
    && (req_op == HCFD_OP_SET_READ || req_op == HCFD_OP_SET_WRITE))
    |-> s_q.tx.bytes[4] == HCFD_ST_REFUSED)
    else $error("settings access not refused");
  a_set_stored: assert property ((req_valid && req_op == HCFD_OP_SET_WRITE
    && s_q.tx.bytes[4] == HCFD_ST_OK) |-> s_q.stored[s_q.arg0[3:0]] == s_q.arg1)
    else $error("written setting not stored");
  a_active_hold: assert property ($changed(active_settings)
    |-> req_valid && req_op == HCFD_OP_RESET)
    else $error("active settings changed without reset");
  a_cs_drop: assert property ((rx_take && s_q.rx == HCFD_RX_CS && rx_data != s_q.sum)
    |=> !s_q.cnf_pend ##1 !req_valid)
    else $error("bad checksum frame answered");
  a_tx_hold: assert property ((tx_valid && !tx_ready && !serial_overflow)
    |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed while stalled");

endmodule : hcfd_top

//--- testbench/hcfd_host_sink.sv
// hcfd_host_sink: host side sink of the outgoing frame stream.
// assumes tx_valid and tx_data come from the decoder on the same clock.
`timescale 1ns/1ps
module hcfd_host_sink
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       ph_q;

  // ************************************************************
  // pacing
  // ************************************************************
  // every other cycle stalled when slow, so bytes must hold
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ph_q <= 1'b0;
    else
      ph_q <= ~ph_q;
  end
  assign tx_ready = !slow || ph_q;

  // ************************************************************
  // capture
  // ************************************************************
  // bytes kept in wire order
  always @(posedge clock)
  begin
    if (rstn && tx_valid && tx_ready)
      got.push_back(tx_data);
  end
endmodule : hcfd_host_sink

//--- testbench/test_host_command_frame_decoder.sv
// test_host_command_frame_decoder: self-checking bench of the frame decoder.
// assumes hcfd_pkg and the host sink model are compiled first.
`timescale 1ns/1ps
module test_host_command_frame_decoder
  import hcfd_pkg::*;
;
  typedef logic [7:0] hcfd_q_t[$];

  logic       clock;
  logic       rstn;
  logic       rx_valid;
  logic       rx_ready;
  logic [7:0] rx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] tx_data;
  logic       evt_valid;
  logic       evt_ready;
  logic [7:0] evt_code;
  logic       serial_overflow;
  logic       peripheral_only;
  logic       serial_restart;
  logic       req_valid;
  logic [7:0] req_op;
  logic [7:0] req_arg;
  hcfd_bank_t active_settings;
  logic       slow;
  int         error_cnt;
  int         total_checks;
  int         req_cnt = 0;

  hcfd_top dut (.clock(clock), .rstn(rstn), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_code(evt_code),
    .serial_overflow(serial_overflow), .peripheral_only(peripheral_only),
    .serial_restart(serial_restart), .req_valid(req_valid), .req_op(req_op),
    .req_arg(req_arg), .active_settings(active_settings));

  hcfd_host_sink host (.clock(clock), .rstn(rstn), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  always #12.5 clock = ~clock;

  // one count per request pulse, taken mid-cycle while it stands
  always @(negedge clock)
  begin
    if (req_valid === 1'b1)
      req_cnt++;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic finish_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic hcfd_q_t mk(logic [7:0] op, hcfd_q_t pay);
    hcfd_q_t    f;
    logic [7:0] cs;
    f = {HCFD_START, op, 8'(pay.size()), 8'h00};
    f = {f, pay};
    cs = 8'h00;
    foreach (f[i])
      cs ^= f[i];
    f.push_back(cs);
    return f;
  endfunction : mk

  // one byte on the host or notice handshake, held until ready
  task automatic hs(bit ev, logic [7:0] b);
    int i;
    rx_valid = !ev;
    evt_valid = ev;
    rx_data = b;
    evt_code = b;
    for (i = 0; i < 200; i++)
    begin
      @(negedge clock);
      if ((ev ? evt_ready : rx_ready) === 1'b1)
        break;
    end
    if (i == 200)
    begin
      error_cnt++;
      finish_test();
    end
    @(posedge clock);
    #2;
  endtask : hs

  task automatic send(logic [7:0] op, hcfd_q_t pay, bit bad);
    hcfd_q_t f;
    f = mk(op, pay);
    if (bad)
      f[f.size()-1] = ~f[f.size()-1];
    foreach (f[i])
      hs(1'b0, f[i]);
    rx_valid = 1'b0;
  endtask : send

  // an empty frame means no answer at all is allowed
  task automatic expect_frame(hcfd_q_t f);
    int i;
    for (i = 0; i < 300 && host.got.size() < f.size(); i++)
      @(negedge clock);
    if (host.got.size() < f.size())
      chk("frame_wait", 8'h00, 8'h01);
    repeat (30) @(negedge clock);
    chk("frame_len", 8'(f.size()), 8'(host.got.size()));
    foreach (f[k])
      chk("frame_byte", f[k], host.got[k]);
    host.got.delete();
    @(posedge clock);
    #2;
  endtask : expect_frame

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_requests();
    hcfd_q_t ops;
    hcfd_q_t none;
    ops = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c,
            8'h0d, 8'h0e, 8'h0f, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f};
    foreach (ops[i])
    begin
      send(ops[i], '{8'h33, 8'h44, 8'h55}, 1'b0);
      expect_frame(mk(ops[i] + 8'h40, '{8'h00}));
      chk("req_op", ops[i], req_op);
      chk("req_arg", 8'h33, req_arg);
      chk("req_count", 8'(i + 1), 8'(req_cnt));
    end
    send(8'h03, none, 1'b0);
    expect_frame(none);
    chk("req_count", 8'(ops.size()), 8'(req_cnt));
    send(8'h01, none, 1'b1);
    expect_frame(none);
    chk("req_count", 8'(ops.size()), 8'(req_cnt));
  endtask : t_requests

  task automatic t_settings();
    // value chosen legal for the one writable index
    send(8'h11, '{8'h02, 8'ha5}, 1'b0);
    expect_frame(mk(8'h51, '{8'h00}));
    chk("active_early", 8'h00, active_settings[2]);
    send(8'h10, '{8'h02}, 1'b0);
    expect_frame(mk(8'h50, '{8'h00, 8'ha5}));
    send(8'h11, '{8'h03, 8'h01}, 1'b0);
    expect_frame(mk(8'h51, '{8'hff}));
    send(8'h10, '{8'h10}, 1'b0);
    expect_frame(mk(8'h50, '{8'hff}));
    peripheral_only = 1'b1;
    send(8'h10, '{8'h02}, 1'b0);
    expect_frame(mk(8'h50, '{8'hff}));
    send(8'h11, '{8'h02, 8'h11}, 1'b0);
    expect_frame(mk(8'h51, '{8'hff}));
    peripheral_only = 1'b0;
    send(8'h00, '{}, 1'b0);
    expect_frame(mk(8'h40, '{8'h00}));
    chk("active_after", 8'ha5, active_settings[2]);
  endtask : t_settings

  task automatic t_notices();
    hcfd_q_t c;
    hcfd_q_t none;
    c = '{8'h82, 8'h84, 8'h86, 8'h87, 8'h88, 8'h8b, 8'h8c, 8'h8d, 8'h9a, 8'h9b,
          8'hc4, 8'hc6};
    foreach (c[i])
    begin
      hs(1'b1, c[i]);
      evt_valid = 1'b0;
      expect_frame(mk(c[i], none));
    end
    // a code outside the notice set is taken and dropped
    hs(1'b1, 8'h83);
    evt_valid = 1'b0;
    expect_frame(none);
  endtask : t_notices

  task automatic t_overflow();
    slow = 1'b1;
    hs(1'b0, 8'h02);
    hs(1'b0, 8'h01);
    rx_valid = 1'b0;
    serial_overflow = 1'b1;
    @(posedge clock);
    #2;
    serial_overflow = 1'b0;
    chk("serial_restart", 8'h01, 8'(serial_restart));
    expect_frame(mk(8'ha2, '{8'h01}));
    // host checks the link again after the fault
    send(8'h01, '{8'h00}, 1'b0);
    expect_frame(mk(8'h41, '{8'h00}));
    slow = 1'b0;
  endtask : t_overflow

  initial
  begin
    clock = 1'b0;
    rstn = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    evt_valid = 1'b0;
    evt_code = 8'h00;
    serial_overflow = 1'b0;
    peripheral_only = 1'b0;
    slow = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    repeat (12) @(posedge clock);
    #2;
    rstn = 1'b1;
    t_requests();
    t_settings();
    t_notices();
    t_overflow();
    finish_test();
  end
endmodule : test_host_command_frame_decoder
